// *** smd_pkg.sv ***
package smd_pkg;
  // clock
  localparam int unsigned CLK_MHZ = 100;

  // command codes
  localparam logic [7:0] CODE_SET_TPOS  = 8'hE0;
  localparam logic [7:0] CODE_SET_TVEL  = 8'hE3;
  localparam logic [7:0] CODE_HALT_SET  = 8'hEC;
  localparam logic [7:0] CODE_HALT_HOLD = 8'h89;
  localparam logic [7:0] CODE_TMO_RST   = 8'h8C;
  localparam logic [7:0] CODE_DEENERGZ  = 8'h86;
  localparam logic [7:0] CODE_ENERGIZE  = 8'h85;
  localparam logic [7:0] CODE_BLK_READ  = 8'hA0;
  localparam logic [7:0] CODE_USB_ONLY  = 8'h9A;

  // interface that a command arrived on
  typedef logic [1:0] smd_iface_t;
  localparam smd_iface_t IFACE_USB = 2'h2;

  // input state encoding
  localparam logic [7:0] IN_NOT_READY = 8'h00;
  localparam logic [7:0] IN_INVALID   = 8'h01;
  localparam logic [7:0] IN_HALT      = 8'h02;
  localparam logic [7:0] IN_TPOS      = 8'h03;
  localparam logic [7:0] IN_TVEL      = 8'h04;

  // velocity magnitude limit, microsteps per 10,000 s
  localparam logic signed [31:0] VEL_MAX = 32'sh1DCD_6500;
  localparam logic signed [31:0] VEL_MIN = 32'shE232_9B00;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TPOS   = 8'h08;
  localparam logic [7:0] REG_TVEL   = 8'h0C;
  localparam logic [7:0] REG_CPOS   = 8'h10;
  localparam logic [7:0] REG_SCALED = 8'h14;
  localparam logic [7:0] REG_USBARG = 8'h18;

  // field positions
  localparam int unsigned CTL_HOST   = 0;
  localparam int unsigned CTL_TMO_EN = 1;

  // block read variable offsets (word aligned)
  localparam logic [7:0] VAR_FLAGS    = 8'h00;
  localparam logic [7:0] VAR_TPOS     = 8'h04;
  localparam logic [7:0] VAR_TVEL     = 8'h08;
  localparam logic [7:0] VAR_CPOS     = 8'h0C;
  localparam logic [7:0] VAR_SCALED   = 8'h10;
  localparam logic [7:0] VAR_IN_STATE = 8'h4C;

  // reset values
  localparam logic HOST_MODE_RST = 1'b1;
  localparam logic TMO_EN_RST    = 1'b0;
  localparam logic DRV_EN_RST    = 1'b1;

  // command timeout
  localparam int unsigned CMD_TMO_MS   = 1000;
  localparam int unsigned TMO_CYC_DFLT = CMD_TMO_MS * 1000 * CLK_MHZ;

  // decoder states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BLK  = 2'b10
  } smd_state_e;
endpackage

// *** smd_blk_if.sv ***
interface smd_blk_if;
  logic       start;
  logic [7:0] offset;
  logic [7:0] len;
  logic [7:0] vbyte;
  logic [7:0] addr;
  logic       busy;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_last;

  modport ctl (output start, offset, len, vbyte,
               input  addr, busy, rsp_valid, rsp_data, rsp_last);
  modport eng (input  start, offset, len, vbyte,
               output addr, busy, rsp_valid, rsp_data, rsp_last);
endinterface

// *** smd_blk_reader.sv ***
module smd_blk_reader (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // variable fetch and response stream
  smd_blk_if.eng   bif
);
  import smd_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] rem;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       rsp_last;
  } smd_rd_s;

  smd_rd_s rd_q;
  smd_rd_s rd_d;

  // one byte per cycle; no back-pressure, the requester sinks every byte
  always_comb
  begin
    rd_d           = rd_q;
    rd_d.rsp_valid = 1'b0;
    rd_d.rsp_last  = 1'b0;
    if (bif.start)
    begin
      rd_d.addr = bif.offset;
      rd_d.rem  = bif.len;
    end
    else if (rd_q.rem != 8'h00)
    begin
      rd_d.rsp_valid = 1'b1;
      rd_d.rsp_data  = bif.vbyte;
      rd_d.rsp_last  = (rd_q.rem == 8'h01);
      rd_d.addr      = rd_q.addr + 8'h01;
      rd_d.rem       = rd_q.rem - 8'h01;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rd_q <= '0;
    else
      rd_q <= rd_d;
  end

  // stream outputs
  assign bif.addr      = rd_q.addr;
  assign bif.busy      = (rd_q.rem != 8'h00);
  assign bif.rsp_valid = rd_q.rsp_valid;
  assign bif.rsp_data  = rd_q.rsp_data;
  assign bif.rsp_last  = rd_q.rsp_last;
endmodule

// *** smd_cmd_decoder.sv ***
// Function
// - commands are quick, 7-bit write, 32-bit write or block read
// - block read streams bytes from requested offset for requested length
// - same command set on all links; usb-only group accepted over usb only
// - code E0 loads signed 32-bit target position
// - target position moves only in host mode, else silently dropped
// - code E3 loads signed target velocity limited to 500,000,000
// - target velocity accelerates toward it only in host mode
// - code EC halts abruptly then loads current position
// - EC clears position-uncertain, input state halt, clears scaled input
// - code 89 halts abruptly, sets uncertain, halt state, clears scaled
// - both halts dropped silently outside host mode
// - code 8C restarts command timeout when enabled
// - code 86 disables motor driver, stepping stops
// - de-energize sets uncertain and de-energized error, red on, fault high
// - code 85 requests driver enable, clears de-energized error
// - energize undoes de-energize but keeps position uncertain
// - motor resumes only when no other error remains
// - input state coded 0 to 4, reported as 8 bits
module smd_cmd_decoder #(
  parameter int unsigned TMO_CYCLES = smd_pkg::TMO_CYC_DFLT
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  // command stream from the link layer
  input  wire logic                     cmd_valid,
  input  wire logic [7:0]               cmd_code,
  input  wire logic [31:0]              cmd_data,
  input  wire smd_pkg::smd_iface_t      cmd_iface,
  output logic                          cmd_ready,
  // other error sources
  input  wire logic                     ext_err,
  // register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  // motion profile side
  output logic signed [31:0]            tgt_pos,
  output logic signed [31:0]            tgt_vel,
  output logic                          go_pos,
  output logic                          go_vel,
  output logic                          halt_now,
  output logic signed [31:0]            cur_pos,
  output logic                          cur_pos_load,
  output logic [7:0]                    in_state,
  output logic                          pos_uncertain,
  output logic                          drv_enable,
  output logic                          red_led,
  output logic                          fault_out,
  // usb-only command
  output logic                          usb_cmd,
  output logic [6:0]                    usb_arg,
  // block read stream
  output logic                          rsp_valid,
  output logic [7:0]                    rsp_data,
  output logic                          rsp_last
);
  import smd_pkg::*;

  typedef struct packed {
    smd_state_e         st;
    logic               cmd_ready;
    logic               blk_start;
    logic [7:0]         blk_off;
    logic [7:0]         blk_len;
    logic               host_mode;
    logic               tmo_en;
    logic [31:0]        tmo_cnt;
    logic               tmo_err;
    logic               ext_err;
    logic signed [31:0] tpos;
    logic signed [31:0] tvel;
    logic signed [31:0] cpos;
    logic signed [31:0] scaled;
    logic [7:0]         in_state;
    logic               pos_unc;
    logic               deen;
    logic               drv_en;
    logic               fault;
    logic               go_pos;
    logic               go_vel;
    logic               halt;
    logic               cpos_load;
    logic               usb_cmd;
    logic [6:0]         usb_arg;
    logic [31:0]        rdata;
  } smd_dec_s;

  smd_dec_s  q;
  smd_dec_s  d;
  smd_blk_if bif ();
  logic      take;
  logic      known;

  // velocity saturation keeps the motion side inside its legal range
  function automatic logic signed [31:0] clamp_vel(input logic signed [31:0] v);
    logic signed [31:0] r;
    r = v;
    if (v > VEL_MAX)
      r = VEL_MAX;
    else if (v < VEL_MIN)
      r = VEL_MIN;
    return r;
  endfunction

  // one byte of the variable map for block reads
  function automatic logic [7:0] var_byte(input logic [7:0] a, input smd_dec_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a[7:2])
      VAR_FLAGS[7:2]:    w = {28'h000_0000, s.ext_err, s.tmo_err, s.deen, s.pos_unc};
      VAR_TPOS[7:2]:     w = s.tpos;
      VAR_TVEL[7:2]:     w = s.tvel;
      VAR_CPOS[7:2]:     w = s.cpos;
      VAR_SCALED[7:2]:   w = s.scaled;
      VAR_IN_STATE[7:2]: w = {24'h00_0000, s.in_state};
      default:           w = 32'h0000_0000;
    endcase
    return w[{a[1:0], 3'b000} +: 8];
  endfunction

  // command accepted this cycle; only idle accepts, so one at a time
  assign take  = cmd_valid && q.cmd_ready;
  assign known = (cmd_code == CODE_SET_TPOS) || (cmd_code == CODE_SET_TVEL)
              || (cmd_code == CODE_HALT_SET) || (cmd_code == CODE_HALT_HOLD)
              || (cmd_code == CODE_TMO_RST) || (cmd_code == CODE_DEENERGZ)
              || (cmd_code == CODE_ENERGIZE) || (cmd_code == CODE_BLK_READ)
              || (cmd_code == CODE_USB_ONLY);

  // block read engine hookup
  assign bif.start  = q.blk_start;
  assign bif.offset = q.blk_off;
  assign bif.len    = q.blk_len;
  assign bif.vbyte  = var_byte(bif.addr, q);

  // next-state logic
  always_comb
  begin
    d           = q;
    d.go_pos    = 1'b0;
    d.go_vel    = 1'b0;
    d.halt      = 1'b0;
    d.cpos_load = 1'b0;
    d.usb_cmd   = 1'b0;
    d.blk_start = 1'b0;
    d.rdata     = 32'h0000_0000;
    // register writes; only control is writable
    if (reg_wr && (reg_addr == REG_CTRL))
    begin
      d.host_mode = reg_wdata[CTL_HOST];
      d.tmo_en    = reg_wdata[CTL_TMO_EN];
    end
    // register reads, unmapped reads give zero
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:   d.rdata = {30'h0000_0000, q.tmo_en, q.host_mode};
        REG_STATUS: d.rdata = {19'h0_0000, q.ext_err, q.drv_en, q.tmo_err, q.deen,
                               q.pos_unc, q.in_state};
        REG_TPOS:   d.rdata = q.tpos;
        REG_TVEL:   d.rdata = q.tvel;
        REG_CPOS:   d.rdata = q.cpos;
        REG_SCALED: d.rdata = q.scaled;
        REG_USBARG: d.rdata = {25'h000_0000, q.usb_arg};
        default:    d.rdata = 32'h0000_0000;
      endcase
    end
    // command timeout; disabling it drops a pending timeout error
    if (q.tmo_en)
    begin
      if (q.tmo_cnt >= 32'(TMO_CYCLES - 1))
      begin
        d.tmo_err = 1'b1;
        d.tmo_cnt = 32'h0000_0000;
      end
      else
        d.tmo_cnt = q.tmo_cnt + 32'h0000_0001;
    end
    else
    begin
      d.tmo_cnt = 32'h0000_0000;
      d.tmo_err = 1'b0;
    end
    // command decode
    case (q.st)
      ST_IDLE:
      begin
        if (take)
        begin
          case (cmd_code)
            CODE_SET_TPOS:
            begin
              if (q.host_mode)
              begin
                d.tpos     = cmd_data;
                d.scaled   = cmd_data;
                d.go_pos   = 1'b1;
                d.in_state = IN_TPOS;
              end
            end
            CODE_SET_TVEL:
            begin
              if (q.host_mode)
              begin
                d.tvel     = clamp_vel(cmd_data);
                d.scaled   = clamp_vel(cmd_data);
                d.go_vel   = 1'b1;
                d.in_state = IN_TVEL;
              end
            end
            CODE_HALT_SET:
            begin
              if (q.host_mode)
              begin
                d.halt      = 1'b1;
                d.cpos      = cmd_data;
                d.cpos_load = 1'b1;
                d.pos_unc   = 1'b0;
                d.in_state  = IN_HALT;
                d.scaled    = 32'sh0000_0000;
              end
            end
            CODE_HALT_HOLD:
            begin
              if (q.host_mode)
              begin
                d.halt     = 1'b1;
                d.pos_unc  = 1'b1;
                d.in_state = IN_HALT;
                d.scaled   = 32'sh0000_0000;
              end
            end
            CODE_TMO_RST:
            begin
              if (q.tmo_en)
                d.tmo_cnt = 32'h0000_0000;
            end
            CODE_DEENERGZ:
            begin
              d.deen    = 1'b1;
              d.pos_unc = 1'b1;
              d.halt    = 1'b1;
            end
            CODE_ENERGIZE:
              d.deen = 1'b0;
            CODE_BLK_READ:
            begin
              d.blk_start = 1'b1;
              d.blk_off   = cmd_data[7:0];
              d.blk_len   = cmd_data[15:8];
              d.st        = ST_BLK;
            end
            CODE_USB_ONLY:
            begin
              if (cmd_iface == IFACE_USB)
              begin
                d.usb_cmd = 1'b1;
                d.usb_arg = cmd_data[6:0];
              end
            end
            default:
              d.st = ST_IDLE;
          endcase
        end
      end
      ST_BLK:
      begin
        // blk_start guards the cycle before the engine reports busy
        if (!bif.busy && !q.blk_start)
          d.st = ST_IDLE;
      end
      default:
        d.st = ST_IDLE;
    endcase
    // driver and fault outputs follow the combined error picture
    d.ext_err   = ext_err;
    d.drv_en    = !d.deen && !d.tmo_err && !ext_err;
    d.fault     = d.deen || d.tmo_err || ext_err;
    d.cmd_ready = (d.st == ST_IDLE);
  end

  // state register
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q           <= '0;
      q.st        <= ST_IDLE;
      q.cmd_ready <= 1'b1;
      q.host_mode <= HOST_MODE_RST;
      q.tmo_en    <= TMO_EN_RST;
      q.in_state  <= IN_NOT_READY;
      q.drv_en    <= DRV_EN_RST;
    end
    else
      q <= d;
  end

  // block read engine
  smd_blk_reader u_reader (
    .core_clk (core_clk),
    .rstn     (rstn),
    .bif      (bif.eng)
  );

  // outputs
  assign cmd_ready     = q.cmd_ready;
  assign reg_rdata     = q.rdata;
  assign tgt_pos       = q.tpos;
  assign tgt_vel       = q.tvel;
  assign go_pos        = q.go_pos;
  assign go_vel        = q.go_vel;
  assign halt_now      = q.halt;
  assign cur_pos       = q.cpos;
  assign cur_pos_load  = q.cpos_load;
  assign in_state      = q.in_state;
  assign pos_uncertain = q.pos_unc;
  assign drv_enable    = q.drv_en;
  assign red_led       = q.fault;
  assign fault_out     = q.fault;
  assign usb_cmd       = q.usb_cmd;
  assign usb_arg       = q.usb_arg;
  assign rsp_valid     = bif.rsp_valid;
  assign rsp_data      = bif.rsp_data;
  assign rsp_last      = bif.rsp_last;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_take(logic [7:0] c);
    cmd_valid && cmd_ready && (cmd_code == c);
  endsequence

  sequence s_host_take(logic [7:0] c);
    s_take(c) ##0 q.host_mode;
  endsequence

  a_w7_payload: assert property (s_take(CODE_USB_ONLY) ##0 (cmd_iface == IFACE_USB)
    |=> usb_cmd && (usb_arg == $past(cmd_data[6:0]))) else $error("7-bit payload lost");
  a_blk_single: assert property (s_take(CODE_BLK_READ) ##0 (cmd_data[15:8] == 8'h01)
    |-> ##3 (rsp_valid && rsp_last) ##1 !rsp_valid) else $error("block read length wrong");
  a_usb_gate: assert property (s_take(CODE_USB_ONLY) ##0 (cmd_iface != IFACE_USB)
    |=> !usb_cmd && $stable(usb_arg)) else $error("usb-only command taken off usb");
  a_pos_accept: assert property (s_host_take(CODE_SET_TPOS)
    |=> go_pos && (tgt_pos == $past(cmd_data)) && (in_state == IN_TPOS))
    else $error("target position not loaded");
  a_pos_ignore: assert property (s_take(CODE_SET_TPOS) ##0 !q.host_mode
    |=> !go_pos && $stable(tgt_pos)) else $error("target position taken outside host mode");
  a_vel_limit: assert property (go_vel |-> (tgt_vel <= VEL_MAX) && (tgt_vel >= VEL_MIN))
    else $error("target velocity beyond limit");
  a_vel_accept: assert property (s_host_take(CODE_SET_TVEL)
    |=> go_vel && (in_state == IN_TVEL)) else $error("target velocity not applied");
  a_setpos_load: assert property (s_host_take(CODE_HALT_SET)
    |=> halt_now && cur_pos_load && (cur_pos == $past(cmd_data)))
    else $error("halt and set position failed");
  a_setpos_flags: assert property (s_host_take(CODE_HALT_SET)
    |=> !pos_uncertain && (in_state == IN_HALT) && (q.scaled == 32'sh0000_0000))
    else $error("halt and set position flags wrong");
  a_hold_flags: assert property (s_host_take(CODE_HALT_HOLD)
    |=> halt_now && pos_uncertain && (in_state == IN_HALT) && (q.scaled == 32'sh0000_0000))
    else $error("halt and hold flags wrong");
  a_halt_ignore: assert property (s_take(CODE_HALT_HOLD) ##0 !q.host_mode
    |=> !halt_now && $stable(in_state)) else $error("halt taken outside host mode");
  a_tmo_restart: assert property (s_take(CODE_TMO_RST) ##0 q.tmo_en ##0 q.cmd_ready
    |=> (q.tmo_cnt == 32'h0000_0000) ##1 (q.tmo_cnt == 32'h0000_0001) or !q.tmo_en)
    else $error("timeout not restarted");
  a_deen_drv: assert property (s_take(CODE_DEENERGZ) |=> !drv_enable && halt_now)
    else $error("driver still enabled");
  a_deen_fault: assert property (s_take(CODE_DEENERGZ)
    |=> fault_out && red_led && pos_uncertain && q.deen) else $error("de-energize flags wrong");
  a_energize_clr: assert property (s_take(CODE_ENERGIZE) |=> !q.deen)
    else $error("de-energized error not cleared");
  a_energize_unc: assert property (s_take(CODE_ENERGIZE) ##0 pos_uncertain
    |=> pos_uncertain) else $error("energize cleared position uncertain");
  a_resume_gate: assert property (drv_enable |-> !q.deen && !q.tmo_err && !q.ext_err)
    else $error("driver enabled with an error active");
  a_state_code: assert property (in_state <= IN_TVEL)
    else $error("input state out of range");
  a_one_at_time: assert property (bif.busy |-> !cmd_ready)
    else $error("command accepted during block read");
  a_unknown_code: assert property (take && !known
    |=> $stable(pos_uncertain) && $stable(tgt_pos) && !halt_now && !go_pos && !go_vel)
    else $error("unknown code changed state");
endmodule

// *** smd_host_model.sv ***
module smd_host_model (
  // clock and handshake
  input  wire logic          core_clk,
  input  wire logic          cmd_ready,
  // command stream
  output logic               cmd_valid,
  output logic [7:0]         cmd_code,
  output logic [31:0]        cmd_data,
  output smd_pkg::smd_iface_t cmd_iface
);
  timeunit 1ns;
  timeprecision 1ns;
  import smd_pkg::*;

  // idle lines at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
    cmd_data  = 32'h0000_0000;
    cmd_iface = 2'h0;
  end

  // one command per beat, held until the taking edge; gap makes a slow host
  task automatic send(input logic [7:0] c, input logic [31:0] d, input smd_iface_t i,
                      input int gap);
    repeat (gap) @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_data  <= d;
    cmd_iface <= i;
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
  endtask

  // released code and data lines show the inverse so stale values never pass as valid
  task automatic idle();
    cmd_valid <= 1'b0;
    cmd_code  <= ~cmd_code;
    cmd_data  <= ~cmd_data;
  endtask
endmodule

// *** smd_cmd_decoder_bench.sv ***
module smd_cmd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import smd_pkg::*;

  localparam int unsigned TMO  = 20;
  localparam logic [31:0] DROP = {CODE_SET_TPOS, CODE_SET_TVEL, CODE_HALT_SET, CODE_HALT_HOLD};

  // stimulus and observed signals
  logic               core_clk, rstn, cmd_valid, cmd_ready, ext_err, reg_wr, reg_rd;
  logic               go_pos, go_vel, halt_now, cur_pos_load, pos_uncertain, drv_enable;
  logic               red_led, fault_out, usb_cmd, rsp_valid, rsp_last;
  logic [6:0]         usb_arg;
  logic [7:0]         cmd_code, reg_addr, in_state, rsp_data;
  logic [31:0]        cmd_data, reg_wdata, reg_rdata, v, acc;
  logic signed [31:0] tgt_pos, tgt_vel, cur_pos;
  smd_iface_t         cmd_iface;
  int                 err_count, n_compared, n, nl;
  int                 cyc = 0;

  // short timeout so the expiry fits the run
  smd_cmd_decoder #(.TMO_CYCLES(TMO)) smd_cmd_decoder_inst (
    .core_clk, .rstn, .cmd_valid, .cmd_code, .cmd_data, .cmd_iface, .cmd_ready,
    .ext_err, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tgt_pos,
    .tgt_vel, .go_pos, .go_vel, .halt_now, .cur_pos, .cur_pos_load, .in_state,
    .pos_uncertain, .drv_enable, .red_led, .fault_out, .usb_cmd, .usb_arg,
    .rsp_valid, .rsp_data, .rsp_last
  );

  smd_host_model smd_host_model_inst (
    .core_clk, .cmd_ready, .cmd_valid, .cmd_code, .cmd_data, .cmd_iface
  );

  // clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // register port: one-cycle strobes, read data only in the next cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  // one command, then look at the cycle after it was taken
  task automatic cmd(input logic [7:0] c, input logic [31:0] d, input smd_iface_t i);
    @(posedge core_clk);
    smd_host_model_inst.send(c, d, i, 1);
    smd_host_model_inst.idle();
    @(negedge core_clk);
  endtask

  // gather the byte stream of a block read, low byte first
  task automatic blk(input logic [7:0] off, input logic [7:0] len, input logic [31:0] exp);
    acc = 32'h0000_0000;
    n   = 0;
    nl  = 0;
    cmd(CODE_BLK_READ, {16'h0000, len, off}, 2'h0);
    chk(cmd_ready, 1'b0);
    repeat (8)
    begin
      @(negedge core_clk);
      if (rsp_valid === 1'b1)
      begin
        acc[8*n+:8] = rsp_data;
        n++;
      end
      if (rsp_last === 1'b1)
        nl++;
    end
    chk(n, len);
    chk(acc, exp);
    chk(nl, 1);
    chk(cmd_ready, 1'b1);
  endtask

  // main sequence
  initial
  begin
    core_clk  = 1'b0;
    rstn      = 1'b0;
    ext_err   = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk({in_state, drv_enable}, {IN_NOT_READY, 1'b1});
    rd(REG_CTRL, v);
    chk(v, 32'h0000_0001);
    rd(8'h40, v);
    chk(v, 32'h0000_0000);
    // back to back: extreme position then an over-range velocity
    @(posedge core_clk);
    smd_host_model_inst.send(CODE_SET_TPOS, 32'h8000_0000, 2'h0, 0);
    smd_host_model_inst.send(CODE_SET_TVEL, 32'h7FFF_FFFF, 2'h1, 0);
    smd_host_model_inst.idle();
    @(negedge core_clk);
    chk(tgt_pos, 32'h8000_0000);
    chk({go_vel, tgt_vel}, {1'b1, VEL_MAX});
    chk(in_state, IN_TVEL);
    cmd(CODE_SET_TPOS, 32'h7FFF_A55A, 2'h0);
    chk({go_pos, in_state}, {1'b1, IN_TPOS});
    blk(VAR_TPOS, 8'h02, 32'h0000_A55A);
    blk(VAR_IN_STATE, 8'h01, {24'h00_0000, IN_TPOS});
    // outside host mode motion and halts are dropped
    wr(REG_CTRL, 32'h0000_0000);
    for (int k = 0; k < 4; k++)
    begin
      cmd(DROP[8*k+:8], 32'h0000_0005, 2'h0);
      chk({go_pos, go_vel, halt_now, cur_pos_load}, 4'h0);
    end
    chk({pos_uncertain, in_state, tgt_pos}, {1'b0, IN_TPOS, 32'h7FFF_A55A});
    chk(tgt_vel, VEL_MAX);
    wr(REG_CTRL, 32'h0000_0001);
    cmd(CODE_HALT_HOLD, 32'h0000_0000, 2'h0);
    chk({halt_now, pos_uncertain, in_state}, {2'b11, IN_HALT});
    rd(REG_SCALED, v);
    chk(v, 32'h0000_0000);
    cmd(CODE_SET_TPOS, 32'h0000_0077, 2'h0);
    cmd(CODE_HALT_SET, 32'hFEDC_BA98, 2'h0);
    chk({halt_now, cur_pos_load, cur_pos}, {2'b11, 32'hFEDC_BA98});
    chk({pos_uncertain, in_state}, {1'b0, IN_HALT});
    rd(REG_SCALED, v);
    chk(v, 32'h0000_0000);
    cmd(8'h55, 32'hFFFF_FFFF, 2'h0);
    chk({halt_now, go_pos, go_vel, pos_uncertain, drv_enable}, 5'b00001);
    chk(cur_pos, 32'hFEDC_BA98);
    // driver off and on, then on again while another error is active
    cmd(CODE_DEENERGZ, 32'h0000_0000, 2'h0);
    chk({halt_now, pos_uncertain, drv_enable, red_led, fault_out}, 5'b11011);
    rd(REG_STATUS, v);
    chk(v[9], 1'b1);
    cmd(CODE_ENERGIZE, 32'h0000_0000, 2'h0);
    chk({pos_uncertain, drv_enable, red_led, fault_out}, 4'b1100);
    rd(REG_STATUS, v);
    chk(v[9], 1'b0);
    @(posedge core_clk);
    ext_err <= 1'b1;
    cmd(CODE_DEENERGZ, 32'h0000_0000, 2'h0);
    cmd(CODE_ENERGIZE, 32'h0000_0000, 2'h0);
    chk(drv_enable, 1'b0);
    @(posedge core_clk);
    ext_err <= 1'b0;
    // usb-only command honoured from usb alone
    cmd(CODE_USB_ONLY, 32'h0000_002A, IFACE_USB);
    chk({usb_cmd, usb_arg}, {1'b1, 7'h2A});
    cmd(CODE_USB_ONLY, 32'h0000_0011, 2'h1);
    chk({usb_cmd, usb_arg}, {1'b0, 7'h2A});
    // most negative velocity saturates at the lower limit
    cmd(CODE_SET_TVEL, 32'h8000_0000, 2'h0);
    chk({go_vel, tgt_vel}, {1'b1, VEL_MIN});
    // restarts keep the timeout away, silence lets it expire
    wr(REG_CTRL, 32'h0000_0003);
    repeat (4)
    begin
      cmd(CODE_TMO_RST, 32'h0000_0000, 2'h0);
      repeat (10) @(posedge core_clk);
    end
    rd(REG_STATUS, v);
    chk(v[10], 1'b0);
    repeat (TMO) @(posedge core_clk);
    rd(REG_STATUS, v);
    chk({v[10], fault_out}, 2'b11);
    results();
  end
endmodule
